// file: design/gcd_pkg.sv
// Shared constants and types for the global clock buffers and their deskew loops.
// Assumes one system clock; pad and loop clocks arrive as sampled waveforms.
package gcd_pkg;

  // ----------------------------------------------------------------
  // Sizes and timing
  // ----------------------------------------------------------------
  localparam int NUM_BUF       = 4;
  localparam int CLK_PERIOD_NS = 8;
  localparam int DEPTH_DEF     = 64;
  localparam int LOCK_DEF      = 4;
  localparam logic RST_LEVEL   = 1'b0;

  // ----------------------------------------------------------------
  // Output selectors for the two driven nets
  // ----------------------------------------------------------------
  localparam logic [2:0] OUT_CLK0   = 3'h0;
  localparam logic [2:0] OUT_CLK90  = 3'h1;
  localparam logic [2:0] OUT_CLK180 = 3'h2;
  localparam logic [2:0] OUT_CLK270 = 3'h3;
  localparam logic [2:0] OUT_CLK2X  = 3'h4;
  localparam logic [2:0] OUT_CLKDV  = 3'h5;

  // ----------------------------------------------------------------
  // Divider codes, counted in quarter periods (doubled-clock edges)
  // ----------------------------------------------------------------
  localparam logic [2:0] DIV_1P5 = 3'h0;
  localparam logic [2:0] DIV_2   = 3'h1;
  localparam logic [2:0] DIV_2P5 = 3'h2;
  localparam logic [2:0] DIV_3   = 3'h3;
  localparam logic [2:0] DIV_4   = 3'h4;
  localparam logic [2:0] DIV_5   = 3'h5;
  localparam logic [2:0] DIV_8   = 3'h6;
  localparam logic [2:0] DIV_16  = 3'h7;

  function automatic logic [5:0] div_quarters(input logic [2:0] code);
    case (code)
      DIV_1P5: div_quarters = 6'h03;
      DIV_2:   div_quarters = 6'h04;
      DIV_2P5: div_quarters = 6'h05;
      DIV_3:   div_quarters = 6'h06;
      DIV_4:   div_quarters = 6'h08;
      DIV_5:   div_quarters = 6'h0A;
      DIV_8:   div_quarters = 6'h10;
      default: div_quarters = 6'h20;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       routeSel;
    logic       dllEn;
    logic       mirror;
    logic       waitLock;
    logic [2:0] divSel;
    logic [2:0] netSelA;
    logic [2:0] netSelB;
  } gcd_cfg_t;

  typedef struct packed {
    logic clk0;
    logic clk90;
    logic clk180;
    logic clk270;
    logic clk2x;
    logic clkdv;
  } gcd_clk_t;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'h0,
    ST_MEASURE = 2'h1,
    ST_TRACK   = 2'h3,
    ST_LOCK    = 2'h2
  } gcd_state_t;

endpackage

// file: design/gcd_gbuf.sv
// One global clock buffer: picks the dedicated pad or a routing signal.
// Assumes the pad is asynchronous to clk and the routing signal is not.
`timescale 1ns/1ps
module gcd_gbuf (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic padClk,
  input  wire logic routeClk,
  input  wire logic routeSel,
  output logic      bufOut
);
  import gcd_pkg::*;

  logic padS1Q;
  logic padS2Q;
  logic bufQ;
  logic bufD;

  assign bufD   = routeSel ? routeClk : padS2Q; // see [R2]
  assign bufOut = bufQ;

  always_ff @(posedge clk) begin
    if (rst) begin
      padS1Q <= RST_LEVEL;
      padS2Q <= RST_LEVEL;
      bufQ   <= RST_LEVEL;
    end else begin
      padS1Q <= padClk;
      padS2Q <= padS1Q;
      bufQ   <= bufD;
    end
  end

  a_gbuf_route: assert property (@(posedge clk) disable iff (rst) // see [R2]
    routeSel |=> bufOut == $past(routeClk))
    else $error("buffer does not follow routing input");

  a_gbuf_pad: assert property (@(posedge clk) disable iff (rst) // see [R2]
    !routeSel && !$past(rst) && !$past(rst, 2) |=> bufOut == $past(padClk, 3))
    else $error("buffer does not follow pad input");

endmodule // gcd_gbuf

// file: design/gcd_top.sv
// Global clock buffers with a deskew loop on each, oversampled at clk.
// Assumes feedback returns from the distributed net or, as a mirror, a pin.
// Function
// [R1] Four global buffers, each drives a net
// [R2] Buffer input from pad or routing
// [R3] Each loop drives up to two nets
// [R4] Delay tuned so feedback aligns one period
// [R5] Quadrature phases and doubled clock generated
// [R6] Divided clock, ratios 1.5 to 16
// [R7] Six clock outputs per loop
// [R8] Mirror mode deskews an off-chip feedback
// [R9] Configuration done held until lock
// [R10] Lock flag cleared by reset, set when settled
`timescale 1ns/1ps
module gcd_top #(
  parameter int DEPTH      = gcd_pkg::DEPTH_DEF,
  parameter int LOCK_COUNT = gcd_pkg::LOCK_DEF
) (
  input  wire logic                                 clk,
  input  wire logic                                 rst,
  input  wire logic [gcd_pkg::NUM_BUF-1:0]          padClk,
  input  wire logic [gcd_pkg::NUM_BUF-1:0]          routeClk,
  input  wire logic [gcd_pkg::NUM_BUF-1:0]          fbInt,
  input  wire logic [gcd_pkg::NUM_BUF-1:0]          fbPad,
  input  wire gcd_pkg::gcd_cfg_t [gcd_pkg::NUM_BUF-1:0] cfg,
  input  wire logic                                 cfgReqDone,
  output logic [gcd_pkg::NUM_BUF-1:0]               globalNet,
  output logic [gcd_pkg::NUM_BUF-1:0]               auxNet,
  output gcd_pkg::gcd_clk_t [gcd_pkg::NUM_BUF-1:0]  clkOut,
  output logic [gcd_pkg::NUM_BUF-1:0]               locked,
  output logic                                      cfgDone
);
  import gcd_pkg::*;

  localparam int TW = $clog2(DEPTH);
  localparam int GW = $clog2(LOCK_COUNT + 1);
  localparam logic [TW-1:0] TAP_MAX = TW'(DEPTH - 1);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (DEPTH < 8 || DEPTH > 256 || (1 << TW) != DEPTH) begin : g_bad_depth
    $error("DEPTH must be a power of two from 8 to 256");
  end
  if (LOCK_COUNT < 1 || LOCK_COUNT > 15) begin : g_bad_lock
    $error("LOCK_COUNT must be 1 to 15");
  end

  // ----------------------------------------------------------------
  // Decoders
  // ----------------------------------------------------------------
  function automatic logic pick(input gcd_clk_t c, input logic [2:0] s);
    case (s)
      OUT_CLK0:   pick = c.clk0;
      OUT_CLK90:  pick = c.clk90;
      OUT_CLK180: pick = c.clk180;
      OUT_CLK270: pick = c.clk270;
      OUT_CLK2X:  pick = c.clk2x;
      OUT_CLKDV:  pick = c.clkdv;
      default:    pick = 1'b0;
    endcase
  endfunction

  // Taps past the end of the line stick at the last one; long periods lose phase accuracy.
  function automatic logic [TW-1:0] clamp_idx(input logic [TW:0] v);
    clamp_idx = (v > {1'b0, TAP_MAX}) ? TAP_MAX : v[TW-1:0];
  endfunction

  logic [NUM_BUF-1:0] bufOut;
  logic [NUM_BUF-1:0] fbPadS1Q;
  logic [NUM_BUF-1:0] fbPadS2Q;
  logic [NUM_BUF-1:0] waitMask;

  always_ff @(posedge clk) begin
    if (rst) begin
      fbPadS1Q <= '0;
      fbPadS2Q <= '0;
    end else begin
      fbPadS1Q <= fbPad;
      fbPadS2Q <= fbPadS1Q;
    end
  end

  // ----------------------------------------------------------------
  // Buffers and loops
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NUM_BUF; g++) begin : g_loop
    logic            refPrevQ;
    logic            fbPrevQ;
    logic            errValidQ;
    logic            dvQ;
    logic            prev2xQ;
    logic            netAQ;
    logic            netBQ;
    logic            globalQ;
    logic [TW-1:0]   sinceQ;
    logic [TW-1:0]   periodQ;
    logic [TW-1:0]   errQ;
    logic [TW-1:0]   tapQ;
    logic [TW-1:0]   tapD;
    logic [GW-1:0]   goodQ;
    logic [5:0]      dvCntQ;
    logic [DEPTH-1:0] lineQ;
    gcd_state_t      stQ;
    gcd_state_t      stD;
    gcd_clk_t        outQ;
    gcd_clk_t        outD;

    wire             refIn     = bufOut[g];
    wire             fbIn      = cfg[g].mirror ? fbPadS2Q[g] : fbInt[g]; // see [R8]
    wire             refRise   = refIn & ~refPrevQ;
    wire             fbRise    = fbIn & ~fbPrevQ;
    wire [TW-1:0]    sincePlus = (sinceQ == TAP_MAX) ? sinceQ : sinceQ + 1'b1;
    wire [TW-1:0]    quarter   = periodQ >> 2;
    wire             tracking  = (stQ == ST_TRACK) || (stQ == ST_LOCK);
    wire             aligned   = (errQ == '0);
    wire             lagging   = errQ <= (periodQ >> 1);
    wire             good      = goodQ == GW'(LOCK_COUNT);
    wire [TW-1:0]    i0        = tapQ;
    wire [TW-1:0]    i1        = clamp_idx({1'b0, tapQ} + {1'b0, quarter});
    wire [TW-1:0]    i2        = clamp_idx({1'b0, tapQ} + {quarter, 1'b0});
    wire [TW-1:0]    i3        = clamp_idx({1'b0, tapQ} + {quarter, 1'b0} + {1'b0, quarter});
    wire [5:0]       dvLast    = div_quarters(cfg[g].divSel) - 6'h01;
    wire             edge2x    = outQ.clk2x ^ prev2xQ;
    wire             pickA     = pick(outQ, cfg[g].netSelA); // see [R3]
    wire             pickB     = pick(outQ, cfg[g].netSelB); // see [R3]

    gcd_gbuf u_gbuf ( // see [R1]
      .clk      (clk),
      .rst      (rst),
      .padClk   (padClk[g]),
      .routeClk (routeClk[g]),
      .routeSel (cfg[g].routeSel),
      .bufOut   (bufOut[g])
    );

    // Feedback lagging by at most half a period means the total delay overshoots one period,
    // but only when the taps hold that much; otherwise the loop is a period short.
    always_comb begin
      tapD = tapQ;
      if (tracking && errValidQ && !aligned) begin // see [R4]
        if (lagging && tapQ >= errQ) begin
          tapD = tapQ - 1'b1;
        end else if (tapQ != TAP_MAX) begin
          tapD = tapQ + 1'b1;
        end
      end
    end

    always_comb begin
      stD = stQ;
      case (stQ)
        ST_IDLE:    stD = ST_MEASURE;
        ST_MEASURE: if (refRise && periodQ != '0) stD = ST_TRACK;
        ST_TRACK:   if (good) stD = ST_LOCK; // see [R10]
        ST_LOCK:    if (errValidQ && !aligned) stD = ST_TRACK;
        default:    stD = ST_IDLE;
      endcase
      if (!cfg[g].dllEn) stD = ST_IDLE;
    end

    always_comb begin
      outD = '0;
      if (cfg[g].dllEn) begin // see [R7]
        outD.clk0   = lineQ[i0];
        outD.clk90  = lineQ[i1]; // see [R5]
        outD.clk180 = lineQ[i2];
        outD.clk270 = lineQ[i3];
        outD.clk2x  = lineQ[i0] ^ lineQ[i1];
        outD.clkdv  = dvQ; // see [R6]
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        refPrevQ  <= 1'b0;
        fbPrevQ   <= 1'b0;
        sinceQ    <= '0;
        periodQ   <= '0;
        errQ      <= '0;
        errValidQ <= 1'b0;
        tapQ      <= '0;
        goodQ     <= '0;
        stQ       <= ST_IDLE;
        lineQ     <= '0;
        outQ      <= '0;
      end else begin
        refPrevQ  <= refIn;
        fbPrevQ   <= fbIn;
        sinceQ    <= refRise ? '0 : sincePlus;
        periodQ   <= refRise ? sincePlus : periodQ;
        errQ      <= fbRise ? (refRise ? '0 : sincePlus) : errQ; // see [R4]
        errValidQ <= fbRise && tracking;
        tapQ      <= cfg[g].dllEn ? tapD : '0;
        if (!tracking || (errValidQ && !aligned)) begin
          goodQ <= '0;
        end else if (errValidQ && !good) begin
          goodQ <= goodQ + 1'b1;
        end
        stQ       <= stD;
        lineQ     <= {lineQ[DEPTH-2:0], refIn};
        outQ      <= outD;
      end
    end

    // Divider toggles every so many doubled-clock edges, giving half ratios too.
    always_ff @(posedge clk) begin
      if (rst || !cfg[g].dllEn) begin
        dvCntQ  <= '0;
        dvQ     <= 1'b0;
        prev2xQ <= 1'b0;
      end else begin
        prev2xQ <= outQ.clk2x;
        if (edge2x) begin // see [R6]
          dvCntQ <= (dvCntQ >= dvLast) ? '0 : dvCntQ + 1'b1;
          dvQ    <= (dvCntQ >= dvLast) ? ~dvQ : dvQ;
        end
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        netAQ   <= 1'b0;
        netBQ   <= 1'b0;
        globalQ <= 1'b0;
      end else begin
        netAQ   <= pickA;
        netBQ   <= pickB;
        globalQ <= cfg[g].dllEn ? netAQ : bufOut[g]; // see [R1]
      end
    end

    assign globalNet[g] = globalQ;
    assign auxNet[g]    = netBQ; // see [R3]
    assign clkOut[g]    = outQ;
    assign locked[g]    = (stQ == ST_LOCK); // see [R10]
    assign waitMask[g]  = cfg[g].waitLock & ~locked[g];

    sequence s_mirror_edge;
      $rose(fbPad[g]) && cfg[g].mirror ##1 cfg[g].mirror ##1 cfg[g].mirror;
    endsequence

    a_mirror_fb_edge: assert property (@(posedge clk) disable iff (rst) // see [R8]
      s_mirror_edge |-> fbRise)
      else $error("mirror feedback edge not seen two cycles later");

    a_tap_step_down: assert property (@(posedge clk) disable iff (rst) // see [R4]
      cfg[g].dllEn && tracking && errValidQ && !aligned && lagging && tapQ >= errQ
      |=> tapQ == $past(tapQ) - 1'b1)
      else $error("delay tap did not step down on lagging feedback");

    a_lock_after_good: assert property (@(posedge clk) disable iff (rst) // see [R10]
      $rose(locked[g]) |-> $past(goodQ) == GW'(LOCK_COUNT) && $past(stQ) == ST_TRACK)
      else $error("lock rose without enough aligned compares");

    a_lock_reset_low: assert property (@(posedge clk) // see [R10]
      rst |=> !locked[g])
      else $error("lock not cleared by reset");

    a_outputs_idle_off: assert property (@(posedge clk) disable iff (rst) // see [R7]
      !cfg[g].dllEn |=> outQ == '0)
      else $error("loop outputs active while disabled");

    a_div_toggle_edge: assert property (@(posedge clk) disable iff (rst) // see [R6]
      cfg[g].dllEn && edge2x && dvCntQ == dvLast |=> dvQ != $past(dvQ))
      else $error("divided clock did not toggle at count end");

    a_net_pick_a: assert property (@(posedge clk) disable iff (rst) // see [R3]
      cfg[g].dllEn && !$past(rst) |=> globalNet[g] == $past(pickA, 2))
      else $error("global net does not carry the selected loop output");
  end

  // ----------------------------------------------------------------
  // Configuration completion
  // ----------------------------------------------------------------
  assign cfgDone = cfgReqDone & ~|waitMask; // see [R9]

  a_cfg_hold_lock: assert property (@(posedge clk) disable iff (rst) // see [R9]
    cfgReqDone && (cfg[0].waitLock && !locked[0]) |-> !cfgDone ##1 (locked[0] || !cfgDone
      || !cfg[0].waitLock || !cfgReqDone))
    else $error("configuration completed before the loop locked");

endmodule // gcd_top

// file: testbench/gcd_board_model.sv
// Board side of the global clock block: clock source and feedback traces.
// Assumes one clk; pad and routing clocks are whole multiples of its period.
`timescale 1ns/1ps
module gcd_board_model #(
  parameter int PAD_HALF = 8,
  parameter int RT_HALF  = 4,
  parameter int DIST     = 3
) (
  input  wire logic       clk,
  input  wire logic       mirrorOn,
  input  wire logic [3:0] netIn,
  output logic      [3:0] padClk,
  output logic      [3:0] routeClk,
  output logic      [3:0] fbInt,
  output logic      [3:0] fbPad
);
  logic [3:0] traceQ [DIST+2];
  int         padCnt = 0;
  int         rtCnt  = 0;

  initial begin
    padClk = 4'h0;
    routeClk = 4'h0;
    fbInt = 4'h0;
    fbPad = 4'h0;
  end

  // ----------------------------------------------------------------
  // Sources and return paths
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    padCnt <= (padCnt + 1) % (2 * PAD_HALF);
    rtCnt <= (rtCnt + 1) % (2 * RT_HALF);
    padClk <= {4{padCnt >= PAD_HALF}};
    routeClk <= {4{rtCnt >= RT_HALF}};
    traceQ[0] <= netIn;
    for (int i = 1; i < DIST + 2; i++) begin
      traceQ[i] <= traceQ[i-1];
    end
    // The unused return path keeps moving, so it never looks like a held copy
    fbInt <= mirrorOn ? ~fbInt : traceQ[DIST-1];
    fbPad <= mirrorOn ? traceQ[DIST+1] : ~fbPad;
  end
endmodule // gcd_board_model

// file: testbench/tb.sv
// Self-checking bench for the global clock buffers and their deskew loops.
// Assumes the board model supplies pad, routing and feedback clocks.
`timescale 1ns/1ps
module tb;
  import gcd_pkg::*;
  localparam int PH = 8;
  logic           clk;
  logic           rst;
  logic           cfgReqDone;
  logic           mirrorOn;
  logic [3:0]     padClk, routeClk, fbInt, fbPad, globalNet, auxNet, locked;
  gcd_cfg_t [3:0] cfg;
  gcd_clk_t [3:0] clkOut;
  logic           cfgDone;
  logic [2:0]     probeSel;
  logic           probe;
  int             mismatches = 0;
  int             checks_done = 0;

  // Selector 7 watches the primary net, 0..5 the loop outputs
  assign probe = (probeSel == 3'h7) ? globalNet[0] : clkOut[0][3'h5 - probeSel];

  gcd_top i_gcd_top (
    .clk(clk), .rst(rst), .padClk(padClk), .routeClk(routeClk), .fbInt(fbInt),
    .fbPad(fbPad), .cfg(cfg), .cfgReqDone(cfgReqDone), .globalNet(globalNet),
    .auxNet(auxNet), .clkOut(clkOut), .locked(locked), .cfgDone(cfgDone));

  gcd_board_model #(.PAD_HALF(PH), .RT_HALF(4), .DIST(3)) i_gcd_board_model (
    .clk(clk), .mirrorOn(mirrorOn), .netIn(globalNet), .padClk(padClk),
    .routeClk(routeClk), .fbInt(fbInt), .fbPad(fbPad));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic final_report();
    if (mismatches == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
      mismatches++;
    end
  endtask

  task automatic timeout(string what);
    $display("[ERR] %s expected done seen timeout", what);
    mismatches++;
    final_report();
  endtask

  function automatic gcd_cfg_t mk(logic rs, logic en, logic mir, logic wl, logic [2:0] dv);
    mk = '{rs, en, mir, wl, dv, OUT_CLK0, OUT_CLK180};
  endfunction

  task automatic wait_lvl(logic v, inout int g);
    for (int n = 0; probe !== v; n++) begin
      if (n == 400) timeout("probe");
      tick();
      g++;
    end
  endtask

  // Rising edge to rising edge, skipping the first partial period
  task automatic gap_of(logic [2:0] sel, output int g);
    probeSel = sel;
    g = 0;
    wait_lvl(1'b0, g);
    wait_lvl(1'b1, g);
    g = 0;
    wait_lvl(1'b0, g);
    wait_lvl(1'b1, g);
  endtask

  task automatic wait_lock();
    for (int n = 0; locked !== 4'hF; n++) begin
      if (n == 3000) timeout("locked");
      tick();
    end
  endtask

  task automatic set_cfg(gcd_cfg_t c);
    @(posedge clk);
    cfg <= {4{c}};
    repeat (4) tick();
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic s_lock();
    tick();
    check("cfgDone", cfgDone, 0);
    wait_lock();
    check("cfgDone", cfgDone, 1);
    repeat (100) tick();
    check("locked", locked, 4'hF);
  endtask

  task automatic s_phases();
    logic [15:0] h;
    int          g;
    h = '0;
    // h[n] is clk0 as seen n samples ago
    for (int i = 0; i < 48; i++) begin
      tick();
      h = {h[14:0], clkOut[0].clk0};
      if (i > 16) begin
        check("clk90", clkOut[0].clk90, h[4]);
        check("clk180", clkOut[0].clk180, h[8]);
        check("clk270", clkOut[0].clk270, h[12]);
        check("clk2x", clkOut[0].clk2x, h[0] ^ h[4]);
        check("globalNet", globalNet, {4{h[2]}});
        check("auxNet", auxNet, {4{h[9]}});
      end
    end
    for (int k = 0; k < 5; k++) begin
      gap_of(3'(k), g);
      check("outGap", g, (k == 4) ? PH : 2 * PH);
    end
  endtask

  task automatic s_divide();
    int r[8] = '{3, 4, 5, 6, 8, 10, 16, 32};
    int g;
    for (int d = 0; d < 8; d++) begin
      set_cfg(mk(1'b0, 1'b1, 1'b0, 1'b1, 3'(d)));
      wait_lock();
      gap_of(OUT_CLKDV, g);
      check("clkdv", g, r[d] * PH);
    end
  endtask

  // Loop is dropped first so that the lock below is a fresh one through the pin
  task automatic s_mirror();
    @(posedge clk);
    mirrorOn <= 1'b1;
    set_cfg(mk(1'b0, 1'b0, 1'b1, 1'b1, DIV_2));
    check("locked", locked, 0);
    set_cfg(mk(1'b0, 1'b1, 1'b1, 1'b1, DIV_2));
    wait_lock();
    check("cfgDone", cfgDone, 1);
    repeat (64) tick();
    check("locked", locked, 4'hF);
    @(posedge clk);
    mirrorOn <= 1'b0;
  endtask

  task automatic s_buffer();
    int g;
    @(posedge clk);
    cfgReqDone <= 1'b0;
    set_cfg(mk(1'b0, 1'b0, 1'b0, 1'b0, DIV_2));
    check("cfgDone", cfgDone, 0);
    gap_of(3'h7, g);
    check("padGap", g, 2 * PH);
    check("nets", globalNet, {4{globalNet[0]}});
    check("clkOut", clkOut, 0);
    @(posedge clk);
    cfgReqDone <= 1'b1;
    set_cfg(mk(1'b1, 1'b0, 1'b0, 1'b0, DIV_2));
    check("cfgDone", cfgDone, 1);
    gap_of(3'h7, g);
    check("routeGap", g, 8);
    set_cfg(mk(1'b1, 1'b0, 1'b0, 1'b1, DIV_2));
    check("cfgDone", cfgDone, 0);
  endtask

  task automatic s_rst_mid();
    set_cfg(mk(1'b0, 1'b1, 1'b0, 1'b1, DIV_2));
    wait_lock();
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) tick();
    check("locked", locked, 0);
    check("cfgDone", cfgDone, 0);
    @(posedge clk);
    rst <= 1'b0;
    repeat (2) tick();
    check("locked", locked, 0);
    wait_lock();
    check("cfgDone", cfgDone, 1);
  endtask

  initial begin
    rst = 1'b1;
    cfgReqDone = 1'b1;
    mirrorOn = 1'b0;
    probeSel = 3'h7;
    cfg = {4{mk(1'b0, 1'b1, 1'b0, 1'b1, DIV_2)}};
    repeat (6) tick();
    check("locked", locked, 0);
    check("cfgDone", cfgDone, 0);
    check("clkOut", clkOut, 0);
    @(posedge clk);
    rst <= 1'b0;
    s_lock();
    s_phases();
    s_divide();
    s_mirror();
    s_buffer();
    s_rst_mid();
    final_report();
  end
endmodule // tb
